// file: hdl/sisd_indicator_top.sv
// switch port indicator driver: register file, status stream, parallel and serial paths
// assumes port status from same-clock logic, strap from a pin, link clock free-running
module sisd_indicator_top
#(
	parameter int BLINK_CYCLES = sisd_pkg::BLINK_CYCLES,
	parameter int REFRESH_CYCLES = sisd_pkg::REFRESH_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic [1:0] indicator_preset_strap,
	input wire sisd_pkg::sisd_port_status_type [sisd_pkg::SER_PORTS-1:0] port_status,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic [sisd_pkg::NUM_IND-1:0] indicator_n,
	output logic serial_indicator_data,
	output logic serial_indicator_clock
);
	logic [1:0] rst_sync;
	logic rst_n;
	logic [1:0] strap;
	logic [7:0] indicator_refresh_ctrl;
	logic [15:0] indicator_function_sel_a;
	logic [15:0] indicator_function_sel_b;
	logic [15:0] indicator_function_assign;
	logic [15:0] indicator_port_enable;
	logic [15:0] indicator_force_map_a;
	logic [15:0] indicator_force_map_b;
	logic indicator_live_update;
	logic [31:0] blink_cnt;
	logic blink;
	logic [31:0] refresh_cnt;
	logic refresh_due;
	logic [sisd_pkg::SLOTS-1:0] port_lit [sisd_pkg::SER_PORTS];
	logic [sisd_pkg::SER_BITS-1:0] next_stream;
	logic [sisd_pkg::SER_PORTS-1:0] next_group_en;
	logic [sisd_pkg::NUM_IND-1:0] next_indicator_n;
	sisd_pkg::sisd_ser_word_type ser_word;
	logic req_tgl;
	logic ack_tgl;
	logic [2:0] ack_sync;
	logic ack_seen;
	logic ser_busy;

	assign rst_n = rst_sync[1];
	assign indicator_live_update = indicator_refresh_ctrl[sisd_pkg::LIVE_BIT];

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [15:0] preset_of(input logic [1:0] sel);
		logic [15:0] r;
		unique case (sel)
			2'h0: r = sisd_pkg::PRESET_0;
			2'h1: r = sisd_pkg::PRESET_1;
			2'h2: r = sisd_pkg::PRESET_2;
			2'h3: r = sisd_pkg::PRESET_3;
		endcase
		return r;
	endfunction

	// stream group g carries port SER_PORTS-1-g
	function automatic int port_of_group(input int g);
		return sisd_pkg::SER_PORTS - 1 - g;
	endfunction

	function automatic logic hit_of(
		input logic strobe,
		input logic [7:0] a,
		input logic [7:0] ofs
	);
		return strobe && a == ofs;
	endfunction

	// lit is active high here; the pins invert it
	function automatic logic lit_of(
		input logic [3:0] code,
		input sisd_pkg::sisd_port_status_type st,
		input logic bl
	);
		logic r;
		r = 1'h0;
		case (code)
			sisd_pkg::FN_LINK: r = st.link;
			sisd_pkg::FN_DUPLEX: r = st.duplex;
			sisd_pkg::FN_ACT: r = st.act & bl;
			sisd_pkg::FN_GIG: r = st.gig;
			sisd_pkg::FN_FAST: r = st.fast;
			sisd_pkg::FN_LINK_ACT: r = st.link & ~(st.act & bl);
			sisd_pkg::FN_GIG_ACT: r = st.link & st.gig & ~(st.act & bl);
			sisd_pkg::FN_FAST_ACT: r = st.link & st.fast & ~(st.act & bl);
			default: r = 1'h0;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] read_of(
		input logic [7:0] a,
		input logic [7:0] rf,
		input logic [15:0] fa,
		input logic [15:0] fb,
		input logic [15:0] asg,
		input logic [15:0] en,
		input logic [15:0] ma,
		input logic [15:0] mb
	);
		logic [15:0] r;
		r = 16'h0000;
		case (a)
			sisd_pkg::OFS_REFRESH: r = {8'h00, rf};
			sisd_pkg::OFS_FUNC_A: r = fa;
			sisd_pkg::OFS_FUNC_B: r = fb;
			sisd_pkg::OFS_ASSIGN: r = asg;
			sisd_pkg::OFS_ENABLE: r = en;
			sisd_pkg::OFS_FORCE_A: r = ma;
			sisd_pkg::OFS_FORCE_B: r = mb;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'h1};

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic [1:0] strap_s3;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
			strap_s3 <= 2'h0;
		end
		else
		begin
			strap_s1 <= indicator_preset_strap;
			strap_s2 <= strap_s1;
			strap_s3 <= strap_s2;
		end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			strap <= 2'h0;
		else if (strap_s2 == strap_s3)
			strap <= strap_s3;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_refresh_ctrl <= sisd_pkg::REFRESH_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_REFRESH))
			indicator_refresh_ctrl <= reg_wdata[7:0];

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_function_sel_a <= sisd_pkg::FUNC_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_FUNC_A))
			indicator_function_sel_a <= reg_wdata;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_function_sel_b <= sisd_pkg::FUNC_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_FUNC_B))
			indicator_function_sel_b <= reg_wdata;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_function_assign <= sisd_pkg::ASSIGN_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_ASSIGN))
			indicator_function_assign <= reg_wdata;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_port_enable <= sisd_pkg::ENABLE_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_ENABLE))
			indicator_port_enable <= reg_wdata;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_force_map_a <= sisd_pkg::FORCE_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_FORCE_A))
			indicator_force_map_a <= reg_wdata;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_force_map_b <= sisd_pkg::FORCE_RESET;
		else if (hit_of(reg_wr, reg_addr, sisd_pkg::OFS_FORCE_B))
			indicator_force_map_b <= reg_wdata;

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= read_of(reg_addr, indicator_refresh_ctrl, indicator_function_sel_a,
				indicator_function_sel_b, indicator_function_assign, indicator_port_enable,
				indicator_force_map_a, indicator_force_map_b);

	// ----------------------------------------
	// blink and refresh timers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			blink_cnt <= 32'h00000000;
			blink <= 1'h0;
		end
		else if (blink_cnt == 32'(BLINK_CYCLES - 1))
		begin
			blink_cnt <= 32'h00000000;
			blink <= ~blink;
		end
		else
			blink_cnt <= blink_cnt + 32'h00000001;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			refresh_cnt <= 32'h00000000;
		else if (refresh_due)
			refresh_cnt <= 32'h00000000;
		else
			refresh_cnt <= refresh_cnt + 32'h00000001;
	assign refresh_due = refresh_cnt >= 32'(REFRESH_CYCLES - 1);

	// ----------------------------------------
	// common status stream
	// ----------------------------------------
	always_comb
	begin
		logic [15:0] fsel;
		logic [3:0] code;
		fsel = 16'h0000;
		code = 4'h0;
		for (int p = 0; p < sisd_pkg::SER_PORTS; p++)
		begin
			if (indicator_function_assign[p])
				fsel = indicator_function_sel_b;
			else
				fsel = indicator_function_sel_a;
			if (fsel == 16'h0000)
				fsel = preset_of(strap);
			for (int s = 0; s < sisd_pkg::SLOTS; s++)
			begin
				code = fsel[s*sisd_pkg::FUNC_W +: sisd_pkg::FUNC_W];
				if (!indicator_port_enable[p])
					port_lit[p][s] = 1'h0;
				else if (indicator_force_map_a[p])
					port_lit[p][s] = blink;
				else if (indicator_force_map_b[p])
					port_lit[p][s] = 1'h1;
				else
					port_lit[p][s] = lit_of(code, port_status[p], blink);
			end
		end
	end

	// serial index 0..3 is port 5, then stream index 4..23 from port 4 down
	always_comb
	begin
		next_stream = '0;
		next_group_en = '0;
		for (int g = 0; g < sisd_pkg::SER_PORTS; g++)
		begin
			next_group_en[g] = indicator_port_enable[port_of_group(g)];
			for (int s = 0; s < sisd_pkg::SLOTS; s++)
				next_stream[g*sisd_pkg::SLOTS + s] =
					~port_lit[port_of_group(g)][sisd_pkg::SLOTS-1-s];
		end
	end

	// ----------------------------------------
	// parallel path
	// ----------------------------------------
	always_comb
	begin
		next_indicator_n = indicator_n;
		if (indicator_live_update)
			next_indicator_n = next_stream[sisd_pkg::SER_BITS-1:sisd_pkg::SLOTS];
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			indicator_n <= '1;
		else
			indicator_n <= next_indicator_n;

	// ----------------------------------------
	// serial path handoff
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			ack_sync <= 3'h0;
		else
			ack_sync <= {ack_sync[1:0], ack_tgl};

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			ack_seen <= 1'h0;
		else if (ack_sync[1] == ack_sync[2])
			ack_seen <= ack_sync[2];
	assign ser_busy = req_tgl != ack_seen;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			req_tgl <= 1'h0;
		else if (refresh_due && !ser_busy)
			req_tgl <= ~req_tgl;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			ser_word <= '{group_en: '0, bits: '1};
		else if (refresh_due && !ser_busy)
		begin
			if (indicator_live_update)
				ser_word.bits <= next_stream;
			ser_word.group_en <= next_group_en;
		end

	sisd_serial_tx u_serial_tx
	(
		.link_clk(link_clk),
		.nrst(nrst),
		.req_tgl(req_tgl),
		.word(ser_word),
		.ack_tgl(ack_tgl),
		.serial_indicator_data(serial_indicator_data),
		.serial_indicator_clock(serial_indicator_clock)
	);
endmodule

// file: hdl/sisd_pkg.sv
// constants, types and register map of the switch port indicator driver
// assumes a 10 MHz core clock and a free-running link clock for the serial path
// How it works
// - twenty parallel indicator outputs, four per copper port
// - a port's parallel group keeps its place when that port is disabled; the serial frame skips a disabled port's group
// - port 4 drives outputs 0-3 down to port 0 on outputs 16-19
// - only ports set in the enable map show status
// - functions come from strap or from select register a or b per assign map
// - up to four functions per port, always four outputs per port
// - stream runs highest port first, index 0 to 23, msb first in a port
// - two force maps pick blink, steady on or automatic per port
// - refresh bit 7 resets set; clearing it freezes the parallel outputs and serial bits, but serial groups still follow the enable map
// - outputs are active low, link, duplex and speed lit low
// - activity shows as blinking
// - parallel and serial paths share one status stream
// - serial data and clock wires carry ports 0 to 5
// - gigabit link with activity and fast link with activity functions
package sisd_pkg;
	localparam int NUM_PORTS = 5;
	localparam int SER_PORTS = 6;
	localparam int SLOTS = 4;
	localparam int NUM_IND = 20;
	localparam int SER_BITS = 24;
	localparam int FUNC_W = 4;
	localparam logic [7:0] OFS_REFRESH = 8'h0F;
	localparam logic [7:0] OFS_FUNC_A = 8'h10;
	localparam logic [7:0] OFS_FUNC_B = 8'h12;
	localparam logic [7:0] OFS_ASSIGN = 8'h14;
	localparam logic [7:0] OFS_ENABLE = 8'h16;
	localparam logic [7:0] OFS_FORCE_A = 8'h18;
	localparam logic [7:0] OFS_FORCE_B = 8'h1A;
	localparam int LIVE_BIT = 7;
	localparam logic [7:0] REFRESH_RESET = 8'h80;
	localparam logic [15:0] FUNC_RESET = 16'h0000;
	localparam logic [15:0] ASSIGN_RESET = 16'h0000;
	localparam logic [15:0] ENABLE_RESET = 16'h003F;
	localparam logic [15:0] FORCE_RESET = 16'h0000;
	localparam int BLINK_TIME_MS = 50;
	localparam int REFRESH_TIME_MS = 30;
	localparam int CLK_HZ = 10000000;
	localparam int BLINK_CYCLES = BLINK_TIME_MS * (CLK_HZ / 1000);
	localparam int REFRESH_CYCLES = REFRESH_TIME_MS * (CLK_HZ / 1000);
	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_LINK = 4'h1,
		FN_DUPLEX = 4'h2,
		FN_ACT = 4'h3,
		FN_GIG = 4'h4,
		FN_FAST = 4'h5,
		FN_LINK_ACT = 4'h6,
		FN_GIG_ACT = 4'h7,
		FN_FAST_ACT = 4'h8
	} sisd_func_type;
	localparam logic [15:0] PRESET_0 = 16'h1234;
	localparam logic [15:0] PRESET_1 = 16'h6245;
	localparam logic [15:0] PRESET_2 = 16'h7820;
	localparam logic [15:0] PRESET_3 = 16'h6200;
	typedef struct packed {
		logic link;
		logic duplex;
		logic gig;
		logic fast;
		logic act;
	} sisd_port_status_type;
	typedef struct packed {
		logic [SER_PORTS-1:0] group_en;
		logic [SER_BITS-1:0] bits;
	} sisd_ser_word_type;
endpackage

// file: hdl/sisd_serial_tx.sv
// serial indicator shifter running on the link clock
// assumes word stays stable from a request toggle until the answering ack toggle
module sisd_serial_tx
(
	input wire logic link_clk,
	input wire logic nrst,
	input wire logic req_tgl,
	input wire sisd_pkg::sisd_ser_word_type word,
	output logic ack_tgl,
	output logic serial_indicator_data,
	output logic serial_indicator_clock
);
	typedef enum logic {SX_IDLE, SX_SHIFT} sisd_sx_type;
	logic [1:0] rst_sync;
	logic link_rst_n;
	logic [2:0] req_sync;
	logic req_seen;
	sisd_sx_type state;
	sisd_pkg::sisd_ser_word_type shadow;
	logic [4:0] idx;
	logic phase;
	logic [2:0] grp;
	assign link_rst_n = rst_sync[1];
	assign grp = 3'(idx >> 2);

	// ----------------------------------------
	// reset and request crossing
	// ----------------------------------------
	always_ff @(posedge link_clk or negedge nrst)
		if (!nrst)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'h1};

	always_ff @(posedge link_clk or negedge link_rst_n)
		if (!link_rst_n)
			req_sync <= 3'h0;
		else
			req_sync <= {req_sync[1:0], req_tgl};

	// ----------------------------------------
	// shifter
	// ----------------------------------------
	always_ff @(posedge link_clk or negedge link_rst_n)
		if (!link_rst_n)
		begin
			state <= SX_IDLE;
			req_seen <= 1'h0;
			ack_tgl <= 1'h0;
			shadow <= '0;
			idx <= 5'h00;
			phase <= 1'h0;
			serial_indicator_data <= 1'h1;
			serial_indicator_clock <= 1'h0;
		end
		else
			unique case (state)
				SX_IDLE:
				begin
					serial_indicator_clock <= 1'h0;
					serial_indicator_data <= 1'h1;
					if (req_sync[1] == req_sync[2] && req_sync[2] != req_seen)
					begin
						req_seen <= req_sync[2];
						shadow <= word;
						idx <= 5'h00;
						phase <= 1'h0;
						state <= SX_SHIFT;
					end
				end
				SX_SHIFT:
				begin
					if (!shadow.group_en[grp] || phase)
					begin
						serial_indicator_clock <= 1'h0;
						phase <= 1'h0;
						if (idx == 5'(sisd_pkg::SER_BITS - 1))
						begin
							ack_tgl <= ~ack_tgl;
							state <= SX_IDLE;
						end
						else
							idx <= idx + 5'h01;
					end
					else
					begin
						serial_indicator_data <= shadow.bits[idx];
						serial_indicator_clock <= 1'h0;
						phase <= 1'h1;
					end
					if (shadow.group_en[grp] && phase)
						serial_indicator_clock <= 1'h1;
				end
			endcase
endmodule

// file: tb/sisd_indicator_asserts.sv
// checker on the ports of the indicator driver top
// assumes it is bound to sisd_indicator_top
module sisd_indicator_asserts
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [19:0] indicator_n,
	input wire logic serial_indicator_data,
	input wire logic serial_indicator_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] en_q;
	logic live_q;
	// ----
	// shadow of enable map and live update bit
	// ----
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			en_q <= sisd_pkg::ENABLE_RESET;
			live_q <= 1'b1;
		end
		else if (reg_wr && reg_addr == sisd_pkg::OFS_ENABLE)
			en_q <= reg_wdata;
		else if (reg_wr && reg_addr == sisd_pkg::OFS_REFRESH)
			live_q <= reg_wdata[7];
	end
	property p_ser_pulse;
		@(posedge link_clk) disable iff (!nrst) serial_indicator_clock |=> !serial_indicator_clock;
	endproperty
	a_ser_pulse: assert property (p_ser_pulse)
		else $error("serial clock high too long");
	property p_ser_setup;
		@(posedge link_clk) disable iff (!nrst) $rose(serial_indicator_clock) |-> $stable(serial_indicator_data);
	endproperty
	a_ser_setup: assert property (p_ser_setup)
		else $error("serial data moved at the clock rise");
	property p_ser_gap;
		@(posedge link_clk) disable iff (!nrst) $changed(serial_indicator_data) |-> !serial_indicator_clock;
	endproperty
	a_ser_gap: assert property (p_ser_gap)
		else $error("serial data moved while clock high");
	property p_dark_low;
		@(posedge sys_clk) disable iff (!nrst) live_q && !en_q[0] |=> indicator_n[19:16] == 4'hF;
	endproperty
	a_dark_low: assert property (p_dark_low)
		else $error("disabled port 0 group lit");
	property p_dark_high;
		@(posedge sys_clk) disable iff (!nrst) live_q && !en_q[4] |=> indicator_n[3:0] == 4'hF;
	endproperty
	a_dark_high: assert property (p_dark_high)
		else $error("disabled port 4 group lit");
	property p_freeze;
		@(posedge sys_clk) disable iff (!nrst) !live_q && !$past(live_q) |-> $stable(indicator_n);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("indicators moved while frozen");
	property p_rd_enable;
		@(posedge sys_clk) disable iff (!nrst) reg_rd && reg_addr == sisd_pkg::OFS_ENABLE |=> reg_rdata == $past(en_q);
	endproperty
	a_rd_enable: assert property (p_rd_enable)
		else $error("enable map read wrong");
	property p_rd_live;
		@(posedge sys_clk) disable iff (!nrst) reg_rd && reg_addr == sisd_pkg::OFS_REFRESH |=> reg_rdata[7] == $past(live_q);
	endproperty
	a_rd_live: assert property (p_rd_live)
		else $error("live update bit read wrong");
	c_serial: cover property (@(posedge link_clk) disable iff (!nrst) $rose(serial_indicator_clock));
	c_freeze: cover property (@(posedge sys_clk) disable iff (!nrst) !live_q && reg_rd);
	c_dark: cover property (@(posedge sys_clk) disable iff (!nrst) live_q && !en_q[4]);
endmodule
bind sisd_indicator_top sisd_indicator_asserts sisd_indicator_asserts_i (.sys_clk(sys_clk), .nrst(nrst),
	.link_clk(link_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .indicator_n(indicator_n), .serial_indicator_data(serial_indicator_data),
	.serial_indicator_clock(serial_indicator_clock));

// file: tb/sisd_led_shifter.sv
// model of the external shift registers on the serial wires
// assumes frames are separated by a long idle serial clock
module sisd_led_shifter
(
	input wire logic ser_data,
	input wire logic ser_clk,
	output logic [23:0] frame,
	output int frame_bits,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] sh = '0;
	int cnt = 0;
	realtime last = 0;
	initial
	begin
		frame = '0;
		frame_bits = 0;
		frames = 0;
	end
	always @(posedge ser_clk)
	begin
		if ($realtime - last > 5000.0)
		begin
			frame = sh;
			frame_bits = cnt;
			frames++;
			sh = '0;
			cnt = 0;
		end
		last = $realtime;
		sh = {sh[22:0], ser_data};
		cnt++;
	end
endmodule

// file: tb/tb_switch_port_led_driver.sv
// bench for the indicator driver: registers, parallel groups, serial frames
// assumes the shifter model on the serial wires and the bound checker
module tb_switch_port_led_driver;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0;
	logic link_clk = 0;
	logic nrst = 0;
	logic [1:0] strap = 2'b00;
	sisd_pkg::sisd_port_status_type [5:0] st = '0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [15:0] reg_rdata;
	logic [19:0] indicator_n;
	logic sdata;
	logic sclk;
	logic [23:0] frame;
	int frame_bits;
	int frames;
	int err_total = 0;
	int samples_checked = 0;
	sisd_indicator_top #(.BLINK_CYCLES(8), .REFRESH_CYCLES(200)) sisd_indicator_top_i (.sys_clk(sys_clk),
		.nrst(nrst), .link_clk(link_clk), .indicator_preset_strap(strap), .port_status(st), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .indicator_n(indicator_n),
		.serial_indicator_data(sdata), .serial_indicator_clock(sclk));
	sisd_led_shifter sisd_led_shifter_i (.ser_data(sdata), .ser_clk(sclk), .frame(frame), .frame_bits(frame_bits),
		.frames(frames));
	initial forever #50 sys_clk = ~sys_clk;
	initial
	begin
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// ----
	// shared tasks
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		cyc(1);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		cyc(1);
		chk("register", exp, reg_rdata);
	endtask
	function automatic logic [19:0] lit_map(input logic [5:0] lit);
		logic [19:0] v;
		v = '1;
		for (int p = 0; p < 5; p++)
			if (lit[p])
				v[(4 - p) * 4 +: 4] = 4'h0;
		return v;
	endfunction
	task automatic watch(input int pa, input int pb);
		logic on;
		logic off;
		on = 0;
		off = 0;
		repeat (24)
		begin
			cyc(1);
			chk("phase", indicator_n[(4 - pa) * 4 +: 4], indicator_n[(4 - pb) * 4 +: 4]);
			on |= indicator_n[(4 - pa) * 4 +: 4] === 4'h0;
			off |= indicator_n[(4 - pa) * 4 +: 4] === 4'hF;
		end
		chk("blink", 2'b11, {on, off});
	endtask
	task automatic wait_frames(input int k);
		int n;
		int t;
		n = frames;
		t = 0;
		while (frames < n + k && t < 3000)
		begin
			cyc(1);
			t++;
		end
		chk("frame wait", 0, t >= 3000);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		chk("dark", 20'hFFFFF, indicator_n);
		rd(8'h0F, 16'h0080);
		rd(8'h16, 16'h003F);
		rd(8'h10, 16'h0000);
		rd(8'h1A, 16'h0000);
		wr(8'h02, 16'h1234);
		rd(8'h02, 16'h0000);
		wr(8'h12, 16'h5678);
		rd(8'h12, 16'h5678);
	endtask
	task automatic t_groups;
		wr(8'h10, 16'h1111);
		for (int p = 0; p < 5; p++)
		begin
			st = '0;
			st[p].link = 1'b1;
			cyc(3);
			chk("group", lit_map(6'(1 << p)), indicator_n);
		end
		wr(8'h10, 16'h1200);
		st = '0;
		st[4].link = 1'b1;
		st[0].duplex = 1'b1;
		cyc(3);
		chk("order", 20'hDFFFE, indicator_n);
	endtask
	task automatic t_enable;
		wr(8'h10, 16'h1111);
		for (int p = 0; p < 6; p++)
			st[p] = 5'h10;
		wr(8'h16, 16'h0003);
		cyc(3);
		chk("enable", lit_map(6'h03), indicator_n);
		wr(8'h16, 16'h001C);
		cyc(3);
		chk("enable", lit_map(6'h1C), indicator_n);
		wr(8'h16, 16'h003F);
	endtask
	task automatic t_assign;
		wr(8'h12, 16'h2222);
		wr(8'h14, 16'h0001);
		cyc(3);
		chk("assign", lit_map(6'h1E), indicator_n);
		wr(8'h14, 16'h0000);
		wr(8'h10, 16'h0000);
		strap = 2'b11;
		cyc(8);
		chk("strap", 20'hEEEEE, indicator_n);
		strap = 2'b10;
		st = '0;
		st[4] = 5'h12;
		st[0] = 5'h14;
		cyc(8);
		chk("dual", 20'hEFFFD, indicator_n);
	endtask
	task automatic t_force;
		wr(8'h10, 16'h1111);
		st = '0;
		wr(8'h1A, 16'h0001);
		cyc(3);
		chk("force on", lit_map(6'h01), indicator_n);
		wr(8'h18, 16'h0011);
		watch(4, 0);
		wr(8'h18, 16'h0000);
		wr(8'h1A, 16'h0000);
	endtask
	task automatic t_act;
		wr(8'h10, 16'h3333);
		st = '0;
		st[0].act = 1'b1;
		st[4].act = 1'b1;
		watch(0, 4);
	endtask
	task automatic t_freeze;
		wr(8'h10, 16'h1111);
		st = '0;
		st[2].link = 1'b1;
		cyc(3);
		wr(8'h0F, 16'h0000);
		st = '0;
		st[1].link = 1'b1;
		cyc(5);
		chk("frozen", lit_map(6'h04), indicator_n);
		rd(8'h0F, 16'h0000);
		wr(8'h0F, 16'h0080);
		cyc(3);
		chk("live", lit_map(6'h02), indicator_n);
	endtask
	task automatic t_serial;
		st = '0;
		st[5].link = 1'b1;
		st[0].link = 1'b1;
		wait_frames(3);
		chk("frame bits", 24, frame_bits);
		chk("frame", 24'h0FFFF0, frame);
		wr(8'h16, 16'h0021);
		st[0].link = 1'b0;
		wait_frames(3);
		chk("short bits", 8, frame_bits);
		chk("short frame", 8'h0F, frame[7:0]);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		err_total++;
		summarize;
	end
	initial
	begin
		repeat (4) @(posedge sys_clk);
		#1;
		nrst = 1;
		cyc(3);
		t_reset;
		t_groups;
		t_enable;
		t_assign;
		t_force;
		t_act;
		t_freeze;
		t_serial;
		summarize;
	end
endmodule
